// >>> rtl/ccqe_pkg.sv
// constants and carrier types shared by the completion-queue create and event block
// assumes a single 125 MHz clock domain and a plain strobe register port
package ccqe_pkg;

	////////////////////////////////////////////////////////////////////////////
	// register offsets (byte addresses)
	localparam logic [7:0] REG_PAGE_CFG   = 8'h00;
	localparam logic [7:0] REG_ADMIN_LO   = 8'h04;
	localparam logic [7:0] REG_ADMIN_HI   = 8'h08;
	localparam logic [7:0] REG_OPCODE     = 8'h0C;
	localparam logic [7:0] REG_CDW10      = 8'h10;
	localparam logic [7:0] REG_CDW11      = 8'h14;
	localparam logic [7:0] REG_PTR_LO     = 8'h18;
	localparam logic [7:0] REG_PTR_HI     = 8'h1C;
	localparam logic [7:0] REG_LIST_ENTRY = 8'h20;
	localparam logic [7:0] REG_GO         = 8'h24;
	localparam logic [7:0] REG_EVT_STS    = 8'h28;
	localparam logic [7:0] REG_EVT_MASK   = 8'h2C;
	localparam logic [7:0] REG_EVT_CODE   = 8'h30;
	localparam logic [7:0] REG_CTRL_STS   = 8'h34;

	////////////////////////////////////////////////////////////////////////////
	// field positions
	localparam int CONTIG_BIT  = 0;
	localparam int IEN_BIT     = 1;
	localparam int QID_LSB     = 0;
	localparam int QSIZE_LSB   = 16;
	localparam int MPS_MSB     = 3;
	localparam int FMT_ACT_MSB = 6;
	localparam int PAUSED_BIT  = 0;
	localparam int LAST_STS_LSB = 16;

	// event status bits
	localparam int EV_RELIAB = 0;
	localparam int EV_TEMP   = 1;
	localparam int EV_SPARE  = 2;
	localparam int EV_NS     = 3;
	localparam int EV_FW     = 4;
	localparam int EV_RESV   = 5;
	localparam int EV_CPL    = 6;
	localparam int NUM_EV    = 7;

	////////////////////////////////////////////////////////////////////////////
	// event type and information codes
	localparam logic [2:0] AEN_TYPE_HEALTH = 3'h1;
	localparam logic [2:0] AEN_TYPE_NOTICE = 3'h2;
	localparam logic [2:0] AEN_TYPE_CSS    = 3'h6;
	localparam logic [7:0] INFO_RELIAB     = 8'h00;
	localparam logic [7:0] INFO_TEMP       = 8'h01;
	localparam logic [7:0] INFO_SPARE      = 8'h02;
	localparam logic [7:0] INFO_NS_CHANGED = 8'h00;
	localparam logic [7:0] INFO_FW_START   = 8'h01;
	localparam logic [7:0] INFO_RESV_LOG   = 8'h00;

	////////////////////////////////////////////////////////////////////////////
	// command and completion constants
	localparam logic [7:0]  CREATE_OPCODE   = 8'h10; // arbitrary value
	localparam logic [14:0] STS_OK          = 15'h0000;
	localparam logic [14:0] STS_BAD_OPCODE  = 15'h0001;
	localparam logic [14:0] STS_BAD_OFFSET  = 15'h0013;
	localparam logic [63:0] CPL_ENTRY_BYTES = 64'h0000_0000_0000_0010;
	localparam int          BASE_PAGE_SHIFT = 12;

	// reset values
	localparam logic [3:0]        RST_MPS  = 4'h0;
	localparam logic [NUM_EV-1:0] RST_MASK = 7'h00;
	localparam logic [7:0]        RST_TAIL = 8'h00;

	////////////////////////////////////////////////////////////////////////////
	// carriers
	typedef struct packed {
		logic       reliab;
		logic       temp;
		logic       spare;
		logic       ns_ident_chg;
		logic       ns_list_chg;
		logic [7:0] fmt_progress;
		logic       fw_start;
		logic       fw_done;
		logic       fw_log_read;
		logic       resv_log;
	} ccqe_events_type;

	typedef struct packed {
		logic [63:0] base;
		logic        is_list;
		logic        ien;
		logic [15:0] qid;
		logic [15:0] qsize;
	} ccqe_queue_type;

	typedef struct packed {
		logic [63:0] addr;
		logic [14:0] status;
	} ccqe_cpl_type;

	typedef struct packed {
		logic       valid;
		logic [2:0] kind;
		logic [7:0] info;
	} ccqe_aen_type;

endpackage

// >>> rtl/ccqe_aen_enc.sv
// event encoder: picks the lowest pending event below the completion bit and gives its type and information code
// assumes pending bits come from registers of the same clock domain
`timescale 1ns/1ps
`default_nettype none

module ccqe_aen_enc (
	input  wire logic [ccqe_pkg::NUM_EV-1:0] pending_i,
	output var  ccqe_pkg::ccqe_aen_type      aen_o
);

	always_comb begin
		aen_o = '0;
		if (pending_i[ccqe_pkg::EV_RELIAB]) begin
			aen_o = {1'b1, ccqe_pkg::AEN_TYPE_HEALTH, ccqe_pkg::INFO_RELIAB}; // RULE1
		end else if (pending_i[ccqe_pkg::EV_TEMP]) begin
			aen_o = {1'b1, ccqe_pkg::AEN_TYPE_HEALTH, ccqe_pkg::INFO_TEMP}; // RULE1
		end else if (pending_i[ccqe_pkg::EV_SPARE]) begin
			aen_o = {1'b1, ccqe_pkg::AEN_TYPE_HEALTH, ccqe_pkg::INFO_SPARE}; // RULE1
		end else if (pending_i[ccqe_pkg::EV_NS]) begin
			aen_o = {1'b1, ccqe_pkg::AEN_TYPE_NOTICE, ccqe_pkg::INFO_NS_CHANGED}; // RULE2
		end else if (pending_i[ccqe_pkg::EV_FW]) begin
			aen_o = {1'b1, ccqe_pkg::AEN_TYPE_NOTICE, ccqe_pkg::INFO_FW_START}; // RULE6
		end else if (pending_i[ccqe_pkg::EV_RESV]) begin
			aen_o = {1'b1, ccqe_pkg::AEN_TYPE_CSS, ccqe_pkg::INFO_RESV_LOG}; // RULE8
		end
	end

endmodule

`default_nettype wire

// >>> rtl/ccqe_top.sv
// create-completion-queue command checker, admin completion poster and event reporter
// assumes host commands are staged through the register port and event pulses
// arrive from logic on the same clock
//
// Functional notes
// RULE1: health info codes: 0 reliability, 1h temperature, 2h spare; 3h-FFh unused.
// RULE2: namespace notice raised when namespace identify data or namespace list change.
// RULE3: namespace utilization changes never raise the namespace notice.
// RULE4: format progress raises notice only on bits 6:0 zero/nonzero transitions.
// RULE5: host then re-reads identify data or fetches the changed namespace log.
// RULE6: firmware activation start raises notice 1h and sets processing paused flag.
// RULE7: firmware notice stays pending until the firmware slot log is read.
// RULE8: command-set event code 0h means reservation log pages are available.
// RULE9: the command creates I/O completion queues; admin queue uses its base register.
// RULE10: host keeps a page pointer list fixed until delete or reset.
// RULE11: only first pointer entry, dwords 10 and 11 are used; others reserved.
// RULE12: contiguous flag set: pointer is 64-bit page-aligned contiguous queue base.
// RULE13: contiguous flag clear: pointer addresses a page-aligned list of page pointers.
// RULE14: host gives the first pointer entry a zero page offset.
// RULE15: host gives every list entry a zero page offset.
// RULE16: any nonzero pointer offset rejects the command with invalid offset status.
// RULE17: contiguous flag is bit 0 of dword 11; one means one buffer.
// RULE18: on completion a status entry is posted to the admin completion queue.
//
// Added by the designer: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

module ccqe_top (
	input  wire logic                     SYS_CLK_I,
	input  wire logic                     SRST_I,
	input  wire logic [7:0]               ADDR_I,
	input  wire logic [31:0]              WDATA_I,
	input  wire logic                     WR_I,
	input  wire logic                     RD_I,
	input  wire ccqe_pkg::ccqe_events_type EVT_I,
	output logic      [31:0]              RDATA_O,
	output logic                          IRQ_O,
	output logic                          PAUSED_O,
	output ccqe_pkg::ccqe_aen_type        AEN_O,
	output logic                          CREATE_O,
	output ccqe_pkg::ccqe_queue_type      QUEUE_O,
	output logic                          CPL_VALID_O,
	output ccqe_pkg::ccqe_cpl_type        CPL_O
);

	////////////////////////////////////////////////////////////////////////////
	// state

	typedef struct packed {
		logic [3:0]                  memory_page_size_setting;
		logic [63:0]                 admin_completion_base_reg;
		logic [7:0]                  opcode;
		logic [31:0]                 cdw10;
		logic [31:0]                 cdw11;
		logic [63:0]                 first_queue_pointer_entry;
		logic                        list_bad;
		logic [ccqe_pkg::NUM_EV-1:0] evt_sts;
		logic [ccqe_pkg::NUM_EV-1:0] evt_mask;
		logic                        processing_paused_flag;
		logic                        fmt_active;
		logic [7:0]                  cq_tail;
		logic [14:0]                 last_sts;
		logic [31:0]                 rdata;
		logic                        irq;
		ccqe_pkg::ccqe_aen_type      aen;
		logic                        create;
		ccqe_pkg::ccqe_queue_type    queue;
		logic                        cpl_valid;
		ccqe_pkg::ccqe_cpl_type      cpl;
	} ccqe_state_type;

	ccqe_state_type         r;
	ccqe_state_type         next_r;
	ccqe_pkg::ccqe_aen_type aen_now;

	////////////////////////////////////////////////////////////////////////////
	// helpers

	// true when the address has bits set below the configured memory page size
	function automatic logic ccqe_off_bad(input logic [63:0] ptr, input logic [3:0] mps);
		logic [63:0] mask;
		mask = (64'h0000_0000_0000_0001 << (ccqe_pkg::BASE_PAGE_SHIFT + int'(mps)))
			- 64'h0000_0000_0000_0001;
		return (ptr & mask) != 64'h0000_0000_0000_0000;
	endfunction

	function automatic logic ccqe_hit(input logic [7:0] addr, input logic [7:0] offs);
		return addr == offs;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// event encoder

	ccqe_aen_enc u_aen_enc (
		.pending_i (r.evt_sts),
		.aen_o     (aen_now)
	);

	////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		logic                        wr;
		logic                        rd;
		logic                        go;
		logic                        fmt_now;
		logic                        bad_op;
		logic                        bad_off;
		logic [14:0]                 sts;
		logic [ccqe_pkg::NUM_EV-1:0] set;
		logic [ccqe_pkg::NUM_EV-1:0] clr;

		next_r = r;
		wr = WR_I;
		rd = RD_I;
		go = wr && ccqe_hit(ADDR_I, ccqe_pkg::REG_GO);
		set = '0;
		clr = '0;
		bad_op = 1'b0;
		bad_off = 1'b0;
		sts = ccqe_pkg::STS_OK;
		fmt_now = 1'b0;
		next_r.create = 1'b0;
		next_r.cpl_valid = 1'b0;

		// register writes
		if (wr) begin
			unique case (ADDR_I)
				ccqe_pkg::REG_PAGE_CFG: begin
					next_r.memory_page_size_setting = WDATA_I[ccqe_pkg::MPS_MSB:0];
				end
				ccqe_pkg::REG_ADMIN_LO: begin
					next_r.admin_completion_base_reg[31:0] = WDATA_I; // RULE9
				end
				ccqe_pkg::REG_ADMIN_HI: begin
					next_r.admin_completion_base_reg[63:32] = WDATA_I; // RULE9
				end
				ccqe_pkg::REG_OPCODE: begin
					next_r.opcode = WDATA_I[7:0];
				end
				ccqe_pkg::REG_CDW10: begin
					next_r.cdw10 = WDATA_I;
				end
				ccqe_pkg::REG_CDW11: begin
					next_r.cdw11 = WDATA_I;
				end
				ccqe_pkg::REG_PTR_LO: begin
					next_r.first_queue_pointer_entry[31:0] = WDATA_I;
				end
				ccqe_pkg::REG_PTR_HI: begin
					next_r.first_queue_pointer_entry[63:32] = WDATA_I;
				end
				ccqe_pkg::REG_LIST_ENTRY: begin
					// list entries are only checked, never stored; the queue pages
					// themselves stay in host memory
					if (ccqe_off_bad({32'h0000_0000, WDATA_I}, r.memory_page_size_setting)) begin
						next_r.list_bad = 1'b1; // RULE16
					end
				end
				ccqe_pkg::REG_EVT_STS: begin
					clr = WDATA_I[ccqe_pkg::NUM_EV-1:0];
					clr[ccqe_pkg::EV_FW] = 1'b0; // RULE7
				end
				ccqe_pkg::REG_EVT_MASK: begin
					next_r.evt_mask = WDATA_I[ccqe_pkg::NUM_EV-1:0];
				end
				default: begin
				end
			endcase
		end

		// command execution: one cycle from the go strobe to the posted entry
		if (go) begin
			bad_op = r.opcode != ccqe_pkg::CREATE_OPCODE; // RULE9
			bad_off = ccqe_off_bad(r.first_queue_pointer_entry, r.memory_page_size_setting)
				|| (!r.cdw11[ccqe_pkg::CONTIG_BIT] && r.list_bad); // RULE16
			if (bad_op) begin
				sts = ccqe_pkg::STS_BAD_OPCODE;
			end else if (bad_off) begin
				sts = ccqe_pkg::STS_BAD_OFFSET;
			end else begin
				next_r.create = 1'b1;
				next_r.queue.base = r.first_queue_pointer_entry; // RULE11 RULE12
				next_r.queue.is_list = !r.cdw11[ccqe_pkg::CONTIG_BIT]; // RULE13 RULE17
				next_r.queue.ien = r.cdw11[ccqe_pkg::IEN_BIT];
				next_r.queue.qid = r.cdw10[ccqe_pkg::QID_LSB +: 16];
				next_r.queue.qsize = r.cdw10[ccqe_pkg::QSIZE_LSB +: 16];
			end
			next_r.cpl_valid = 1'b1; // RULE18
			next_r.cpl.addr = r.admin_completion_base_reg
				+ ({56'h0, r.cq_tail} * ccqe_pkg::CPL_ENTRY_BYTES); // RULE18
			next_r.cpl.status = sts;
			// tail wraps after 256 posts; the host must have drained that slot by then
			next_r.cq_tail = r.cq_tail + 8'h01;
			next_r.last_sts = sts;
			next_r.list_bad = 1'b0;
			set[ccqe_pkg::EV_CPL] = 1'b1;
		end

		// event detection
		fmt_now = EVT_I.fmt_progress[ccqe_pkg::FMT_ACT_MSB:0] != 7'h00;
		next_r.fmt_active = fmt_now;
		set[ccqe_pkg::EV_RELIAB] = EVT_I.reliab; // RULE1
		set[ccqe_pkg::EV_TEMP] = EVT_I.temp; // RULE1
		set[ccqe_pkg::EV_SPARE] = EVT_I.spare; // RULE1
		// utilization changes have no input here, so they can never raise it
		set[ccqe_pkg::EV_NS] = EVT_I.ns_ident_chg || EVT_I.ns_list_chg // RULE2 RULE3
			|| (fmt_now != r.fmt_active); // RULE4
		set[ccqe_pkg::EV_FW] = EVT_I.fw_start; // RULE6
		set[ccqe_pkg::EV_RESV] = EVT_I.resv_log; // RULE8
		clr[ccqe_pkg::EV_FW] = EVT_I.fw_log_read; // RULE7

		// set wins over a clear in the same cycle
		next_r.evt_sts = (r.evt_sts & ~clr) | set;

		// an activation start wins over a done pulse in the same cycle
		if (EVT_I.fw_start) begin
			next_r.processing_paused_flag = 1'b1; // RULE6
		end else if (EVT_I.fw_done) begin
			next_r.processing_paused_flag = 1'b0;
		end

		// irq follows this cycle's status so it never lags a status read
		next_r.irq = (next_r.evt_sts & next_r.evt_mask) != '0;
		// the event word lags status by one cycle through the encoder
		next_r.aen = aen_now;

		// register reads, answered one cycle later
		next_r.rdata = 32'h0000_0000;
		if (rd) begin
			unique case (ADDR_I)
				ccqe_pkg::REG_PAGE_CFG: begin
					next_r.rdata = {28'h0, r.memory_page_size_setting};
				end
				ccqe_pkg::REG_ADMIN_LO: begin
					next_r.rdata = r.admin_completion_base_reg[31:0];
				end
				ccqe_pkg::REG_ADMIN_HI: begin
					next_r.rdata = r.admin_completion_base_reg[63:32];
				end
				ccqe_pkg::REG_OPCODE: begin
					next_r.rdata = {24'h0, r.opcode};
				end
				ccqe_pkg::REG_CDW10: begin
					next_r.rdata = r.cdw10;
				end
				ccqe_pkg::REG_CDW11: begin
					next_r.rdata = r.cdw11;
				end
				ccqe_pkg::REG_PTR_LO: begin
					next_r.rdata = r.first_queue_pointer_entry[31:0];
				end
				ccqe_pkg::REG_PTR_HI: begin
					next_r.rdata = r.first_queue_pointer_entry[63:32];
				end
				ccqe_pkg::REG_EVT_STS: begin
					next_r.rdata = {25'h0, r.evt_sts};
				end
				ccqe_pkg::REG_EVT_MASK: begin
					next_r.rdata = {25'h0, r.evt_mask};
				end
				ccqe_pkg::REG_EVT_CODE: begin
					next_r.rdata = {20'h0, aen_now};
				end
				ccqe_pkg::REG_CTRL_STS: begin
					// bits 15:9 and 31 read as zero
					next_r.rdata[ccqe_pkg::PAUSED_BIT] = r.processing_paused_flag; // RULE6
					next_r.rdata[7:1] = r.cq_tail[6:0];
					next_r.rdata[8] = r.list_bad;
					next_r.rdata[ccqe_pkg::LAST_STS_LSB +: 15] = r.last_sts;
				end
				default: begin
					next_r.rdata = 32'h0000_0000;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// registers

	always_ff @(posedge SYS_CLK_I) begin
		if (SRST_I) begin
			r <= '0;
			r.memory_page_size_setting <= ccqe_pkg::RST_MPS;
			r.evt_mask <= ccqe_pkg::RST_MASK;
			r.cq_tail <= ccqe_pkg::RST_TAIL;
		end else begin
			r <= next_r;
		end
	end

	assign RDATA_O = r.rdata;
	assign IRQ_O = r.irq;
	assign PAUSED_O = r.processing_paused_flag;
	assign AEN_O = r.aen;
	assign CREATE_O = r.create;
	assign QUEUE_O = r.queue;
	assign CPL_VALID_O = r.cpl_valid;
	assign CPL_O = r.cpl;

endmodule

`default_nettype wire

// >>> testbench/ccqe_top_properties.sv
// assertions on the ports of ccqe_top, bound into every instance
// assumes one clock domain with a synchronous active high reset
`timescale 1ns/1ps
`default_nettype none

module ccqe_top_properties (
	input wire logic                      SYS_CLK_I,
	input wire logic                      SRST_I,
	input wire logic [7:0]                ADDR_I,
	input wire logic                      WR_I,
	input wire ccqe_pkg::ccqe_events_type EVT_I,
	input wire logic                      PAUSED_O,
	input wire ccqe_pkg::ccqe_aen_type    AEN_O,
	input wire logic                      CREATE_O,
	input wire logic                      CPL_VALID_O,
	input wire ccqe_pkg::ccqe_cpl_type    CPL_O
);
	default clocking @(posedge SYS_CLK_I); endclocking
	default disable iff (SRST_I);

	////////////////////////////////////////////////////////////////////////////
	sequence s_go; WR_I && ADDR_I == ccqe_pkg::REG_GO; endsequence
	sequence s_post; ##1 CPL_VALID_O; endsequence
	property p_post; s_go |-> s_post; endproperty
	a_post: assert property (p_post) else $error("go without completion");
	property p_ok; CREATE_O |-> CPL_VALID_O && CPL_O.status == 15'h0000; endproperty
	a_ok: assert property (p_ok) else $error("create without ok status");
	property p_bad; CPL_VALID_O && CPL_O.status != 15'h0000 |-> !CREATE_O; endproperty
	a_bad: assert property (p_bad) else $error("failed command created a queue");
	// the tail wraps only after 256 posts, which no run reaches
	property p_step; CPL_VALID_O && $past(CPL_VALID_O) |->
		CPL_O.addr == $past(CPL_O.addr) + 64'h10; endproperty
	a_step: assert property (p_step) else $error("completion slot not advanced");
	property p_pause; EVT_I.fw_start |=> PAUSED_O; endproperty
	a_pause: assert property (p_pause) else $error("activation did not pause");
	property p_health; AEN_O.valid && AEN_O.kind == 3'h1 |-> AEN_O.info < 8'h03; endproperty
	a_health: assert property (p_health) else $error("reserved health code");
	property p_notice; AEN_O.valid && AEN_O.kind == 3'h2 |-> AEN_O.info < 8'h02; endproperty
	a_notice: assert property (p_notice) else $error("reserved notice code");
	property p_css; AEN_O.valid && AEN_O.kind == 3'h6 |-> AEN_O.info == 8'h00; endproperty
	a_css: assert property (p_css) else $error("reserved command set code");
endmodule

bind ccqe_top ccqe_top_properties u_ccqe_top_properties (.SYS_CLK_I, .SRST_I, .ADDR_I,
	.WR_I, .EVT_I, .PAUSED_O, .AEN_O, .CREATE_O, .CPL_VALID_O, .CPL_O);

`default_nettype wire

// >>> testbench/ccqe_host_model.sv
// host software model: register port master that stages and issues commands
// assumes the block answers reads one cycle late and never stalls
`timescale 1ns/1ps
`default_nettype none

module ccqe_host_model (
	input  wire logic        clk_i,
	input  wire logic [31:0] rdata_i,
	output var  logic [7:0]  addr_o,
	output var  logic [31:0] wdata_o,
	output var  logic        wr_o,
	output var  logic        rd_o
);
	initial begin
		addr_o = 8'h00;
		wdata_o = 32'h0000_0000;
		wr_o = 1'b0;
		rd_o = 1'b0;
	end

	// n above one holds the strobe for back-to-back writes of one word
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input int n);
		@(posedge clk_i);
		addr_o <= a;
		wdata_o <= d;
		wr_o <= 1'b1;
		repeat (n) @(posedge clk_i);
		wr_o <= 1'b0;
		// released data shows the inverse so a stale word cannot pass
		wdata_o <= ~d;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk_i);
		addr_o <= a;
		rd_o <= 1'b1;
		@(posedge clk_i);
		rd_o <= 1'b0;
		@(posedge clk_i);
		d = rdata_i;
	endtask

	task automatic list_entry(input logic [31:0] e);
		wr(ccqe_pkg::REG_LIST_ENTRY, e, 1);
	endtask

	// only the opcode, the pointer and dwords 10 and 11 are staged
	task automatic create(input logic [7:0] op, input logic [31:0] c10,
		input logic [31:0] c11, input logic [63:0] p, input int n);
		wr(ccqe_pkg::REG_OPCODE, {24'h00_0000, op}, 1);
		wr(ccqe_pkg::REG_CDW10, c10, 1);
		wr(ccqe_pkg::REG_CDW11, c11, 1);
		wr(ccqe_pkg::REG_PTR_LO, p[31:0], 1);
		wr(ccqe_pkg::REG_PTR_HI, p[63:32], 1);
		wr(ccqe_pkg::REG_GO, 32'h0000_0000, n);
	endtask
endmodule

`default_nettype wire

// >>> testbench/ccqe_bench.sv
// self-checking bench: register port, events, interrupt and queue create
// assumes the host model owns the register port and the bench drives event pulses
`timescale 1ns/1ps
`default_nettype none

module ccqe_bench;
	logic                      clk = 1'b0;
	logic                      srst = 1'b1;
	logic [8:0]                pl = 9'h000;
	logic [7:0]                fmt = 8'h00;
	logic [7:0]                addr;
	logic [31:0]               wdata, rdata;
	logic                      wr, rd, irq, paused, create, cpl_valid;
	ccqe_pkg::ccqe_events_type evt;
	ccqe_pkg::ccqe_aen_type    aen;
	ccqe_pkg::ccqe_queue_type  queue;
	ccqe_pkg::ccqe_cpl_type    cpl;
	int                        mismatches = 0;
	int                        checked = 0;

	// pulse index: 0 reliab 1 temp 2 spare 3 ns list 4 fw start 5 resv 6 ns ident 7 done 8 log
	assign evt = {pl[0], pl[1], pl[2], pl[6], pl[3], fmt, pl[4], pl[7], pl[8], pl[5]};
	always #4 clk = ~clk;

	ccqe_top u_ccqe_top (.SYS_CLK_I(clk), .SRST_I(srst), .ADDR_I(addr), .WDATA_I(wdata),
		.WR_I(wr), .RD_I(rd), .EVT_I(evt), .RDATA_O(rdata), .IRQ_O(irq), .PAUSED_O(paused),
		.AEN_O(aen), .CREATE_O(create), .QUEUE_O(queue), .CPL_VALID_O(cpl_valid), .CPL_O(cpl));
	ccqe_host_model u_ccqe_host_model (.clk_i(clk), .rdata_i(rdata), .addr_o(addr),
		.wdata_o(wdata), .wr_o(wr), .rd_o(rd));

	////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [127:0] g, input logic [127:0] e);
		checked++;
		if (g !== e) begin
			mismatches++;
			$display("CHECK FAILED at %0t: got %0h expected %0h", $time, g, e);
		end
	endtask

	task automatic finish_test;
		$display("mismatches %0d checked %0d", mismatches, checked);
		if (mismatches == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic w(input logic [7:0] a, input logic [31:0] d);
		u_ccqe_host_model.wr(a, d, 1);
	endtask

	task automatic r(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] v;
		u_ccqe_host_model.rd(a, v);
		chk(v, e);
	endtask

	task automatic pulse(input int k);
		@(posedge clk);
		pl <= 9'h001 << k;
		@(posedge clk);
		pl <= 9'h000;
		#1;
	endtask

	task automatic post(input logic [14:0] st, input logic ok, input int i);
		#1;
		chk(cpl_valid, 1'b1);
		chk(cpl.status, st);
		chk(create, ok);
		chk(cpl.addr, 64'h1_0010_0000 + 64'h10 * i);
	endtask

	////////////////////////////////////////////////////////////////////////////
	task automatic t_regs;
		r(8'h00, 32'h0);
		r(8'h2C, 32'h0);
		r(8'h34, 32'h0);
		w(8'h40, 32'hFFFF_FFFF);
		r(8'h40, 32'h0);
		w(8'h04, 32'h0010_0000);
		w(8'h08, 32'h1);
		r(8'h04, 32'h0010_0000);
		r(8'h08, 32'h1);
	endtask

	task automatic t_events;
		logic [2:0] kd [6] = '{3'h1, 3'h1, 3'h1, 3'h2, 3'h2, 3'h6};
		logic [7:0] inf [6] = '{8'h00, 8'h01, 8'h02, 8'h00, 8'h01, 8'h00};
		for (int k = 0; k < 6; k++) begin
			pulse(k);
			if (k == 4) chk(paused, 1'b1);
			r(8'h28, 32'h1 << k);
			r(8'h30, {20'h0, 1'b1, kd[k], inf[k]});
			chk(aen, {1'b1, kd[k], inf[k]});
			w(8'h28, 32'h1 << k);
			if (k == 4) begin
				r(8'h28, 32'h10);
				pulse(7);
				chk(paused, 1'b0);
				pulse(8);
			end
			r(8'h28, 32'h0);
		end
		pulse(6);
		r(8'h28, 32'h8);
		r(8'h30, 32'h0000_0A00);
		w(8'h28, 32'h8);
	endtask

	task automatic t_irq;
		w(8'h2C, 32'hFF);
		r(8'h2C, 32'h7F);
		w(8'h2C, 32'h2);
		pulse(0);
		chk(irq, 1'b0);
		pulse(1);
		chk(irq, 1'b1);
		w(8'h28, 32'h3);
		#1;
		chk(irq, 1'b0);
		w(8'h2C, 32'h0);
	endtask

	// only crossings of zero in bits 6:0 count; bit 7 alone is ignored
	task automatic t_fmt;
		logic [7:0] fv [5] = '{8'h80, 8'h81, 8'h82, 8'h00, 8'h80};
		logic [4:0] ev = 5'h0A;
		for (int i = 0; i < 5; i++) begin
			@(posedge clk);
			fmt <= fv[i];
			r(8'h28, {28'h0, ev[i], 3'h0});
			w(8'h28, 32'h8);
		end
	endtask

	task automatic t_create;
		u_ccqe_host_model.create(8'h10, 32'h0003_0005, 32'h3, 64'h1_2345_6000, 1);
		post(15'h0000, 1'b1, 0);
		chk(queue, {64'h1_2345_6000, 1'b0, 1'b1, 16'h0005, 16'h0003});
		u_ccqe_host_model.list_entry(32'h0000_7000);
		u_ccqe_host_model.create(8'h10, 32'h0001_0002, 32'h0, 64'h8000, 2);
		post(15'h0000, 1'b1, 2);
		chk(queue, {64'h8000, 1'b1, 1'b0, 16'h0002, 16'h0001});
		u_ccqe_host_model.create(8'h10, 32'h0001_0002, 32'h1, 64'h1_2345_6010, 1);
		post(15'h0013, 1'b0, 3);
		chk(queue.base, 64'h8000);
		r(8'h34, 32'h0013_0008);
		u_ccqe_host_model.list_entry(32'h0000_7008);
		r(8'h34, 32'h0013_0108);
		u_ccqe_host_model.create(8'h10, 32'h0001_0002, 32'h0, 64'h8000, 1);
		post(15'h0013, 1'b0, 4);
		u_ccqe_host_model.create(8'h11, 32'h0001_0002, 32'h1, 64'h1_2345_6010, 1);
		post(15'h0001, 1'b0, 5);
		w(8'h00, 32'h1);
		u_ccqe_host_model.create(8'h10, 32'h0001_0002, 32'h1, 64'h1000, 1);
		post(15'h0013, 1'b0, 6);
		u_ccqe_host_model.create(8'h10, 32'h0001_0002, 32'hFFFD, 64'h2000, 1);
		post(15'h0000, 1'b1, 7);
		chk(queue.ien, 1'b0);
		r(8'h14, 32'h0000_FFFD);
		r(8'h18, 32'h0000_2000);
		r(8'h0C, 32'h0000_0010);
		r(8'h34, 32'h0000_0010);
	endtask

	// a second reset in mid-run must clear status, tail and page size
	task automatic t_reset;
		@(posedge clk);
		srst <= 1'b1;
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		r(8'h00, 32'h0);
		r(8'h28, 32'h0);
		r(8'h34, 32'h0);
		chk(queue, '0);
		chk(cpl, '0);
		chk(cpl_valid, 1'b0);
	endtask

	initial begin
		repeat (3) @(posedge clk);
		srst <= 1'b0;
		t_regs();
		t_events();
		t_irq();
		t_fmt();
		t_create();
		t_reset();
		finish_test();
	end
endmodule

`default_nettype wire
